/* design/rsc_pkg.sv */
// Notes on behaviour
// - enable bits: 1 enables, 0 disables; reset 1
// - enable and flag registers share one layout
// - flag register read-only, reset zero, read clears
// - state set by pins and command register
// - transition code reported; only off and forced-off commands act meanwhile
// - sleep pin rise: idle, listen, pll-ready
// - reset pin restores defaults except clock control
// - reset pin leaves power-on state unchanged
// - off and forced-off lead to idle
// - forced-off aborts frame, idle at once outside power-on
// - off during frame waits for frame end
// - power-on state, clock out once crystal stable
// - power-on reset loads every register default
// - pull resistors on only in power-on state
// - off command leaves power-on once crystal stable
// - sleep reachable only from idle by pin
// - clock on: sleep 35 output cycles later
// - clock control zero: sleep at once
// - all flags ORed onto interrupt output
// - flag read also drops interrupt output
// - flags sticky; lock and unlock clear each other
// - falling sleep pin wakes sleep to idle
package rsc_pkg;

	// ****************************************************
	// register map
	// ****************************************************
	localparam logic [5:0] ADDR_STATUS  = 6'h01;
	localparam logic [5:0] ADDR_COMMAND = 6'h02;
	localparam logic [5:0] ADDR_CTRL0   = 6'h03;
	localparam logic [5:0] ADDR_ENABLE  = 6'h0E;
	localparam logic [5:0] ADDR_FLAGS   = 6'h0F;

	localparam logic [7:0] ENABLE_RESET  = 8'hFF;
	localparam logic [7:0] FLAGS_RESET   = 8'h00;
	localparam logic [7:0] COMMAND_RESET = 8'h00;
	localparam logic [3:0] CTRL0_RESET   = 4'h1;
	localparam logic [7:0] RESERVED_MASK = 8'h30;

	// ****************************************************
	// field positions
	// ****************************************************
	localparam int BIT_LOW_BATTERY = 7;
	localparam int BIT_UNDERRUN    = 6;
	localparam int BIT_FRAME_END   = 3;
	localparam int BIT_RX_START    = 2;
	localparam int BIT_PLL_UNLOCK  = 1;
	localparam int BIT_PLL_LOCK    = 0;
	localparam int CLKOUT_CTRL_MSB = 2;
	localparam int SHADOW_SEL_BIT  = 3;

	// ****************************************************
	// commands and status codes
	// ****************************************************
	localparam logic [7:0] CMD_TX_START  = 8'h02;
	localparam logic [7:0] CMD_FORCE_OFF = 8'h03;
	localparam logic [7:0] CMD_RX_ON     = 8'h06;
	localparam logic [7:0] CMD_OFF       = 8'h08;
	localparam logic [7:0] CMD_PLL_ON    = 8'h09;

	localparam logic [7:0] CODE_P_ON       = 8'h00;
	localparam logic [7:0] CODE_BUSY_RX    = 8'h01;
	localparam logic [7:0] CODE_BUSY_TX    = 8'h02;
	localparam logic [7:0] CODE_RX_ON      = 8'h06;
	localparam logic [7:0] CODE_IDLE       = 8'h08;
	localparam logic [7:0] CODE_PLL_ON     = 8'h09;
	localparam logic [7:0] CODE_SLEEP      = 8'h0F;
	localparam logic [7:0] CODE_RX_NOCLK   = 8'h1C;
	localparam logic [7:0] CODE_TRANSITION = 8'h1F;

	// ****************************************************
	// timing and serial framing
	// ****************************************************
	localparam int         CLK_FREQ_HZ         = 10_000_000;
	localparam int         CLKOUT_DIV          = 2;
	localparam int         OUT_CYCLES_TO_SLEEP = 35;
	localparam logic [6:0] SLEEP_DELAY_CYC     = 7'(OUT_CYCLES_TO_SLEEP * CLKOUT_DIV);
	localparam logic [2:0] TRANSITION_CYC      = 3'h4;
	localparam logic [4:0] SPI_ADDR_LAST       = 5'h07;
	localparam logic [4:0] SPI_DATA_FIRST      = 5'h08;
	localparam logic [4:0] SPI_FRAME_LAST      = 5'h0F;
	localparam logic [4:0] SPI_FRAME_BITS      = 5'h10;

	typedef enum logic [3:0] {
		S_P_ON, S_IDLE, S_SLEEP_WAIT, S_SLEEP, S_RX_ON, S_RX_NOCLK,
		S_BUSY_RX, S_PLL_ON, S_BUSY_TX, S_TRANS
	} rsc_state_type;

endpackage

/* design/rsc_radio_ctrl.sv */
`timescale 1ns/1ps
module rsc_radio_ctrl
	import rsc_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic sclk,
	input  wire logic sel_n,
	input  wire logic mosi,
	output logic      miso,
	output logic      miso_oe,
	input  wire logic reset_pin_n,
	input  wire logic sleep_transmit_pin,
	input  wire logic crystal_stable,
	input  wire logic ev_low_battery,
	input  wire logic ev_buffer_underrun,
	input  wire logic ev_frame_end,
	input  wire logic ev_rx_start,
	input  wire logic ev_pll_unlock,
	input  wire logic ev_pll_lock,
	output logic      irq,
	output logic      clock_output_pin,
	output logic      pullup_enable,
	output logic      frame_abort,
	output logic [7:0] state_code
);

	// ****************************************************
	// declarations
	// ****************************************************
	logic [4:0]    bit_cnt;
	logic [7:0]    shift_in;
	logic          frame_ok;
	logic [5:0]    spi_addr;
	logic [7:0]    spi_data;
	logic          rd_req;
	logic          wr_req;
	logic          wr_bit;
	logic [2:0]    rd_sync;
	logic [2:0]    wr_sync;
	logic [1:0]    rst_sync;
	logic [1:0]    xtal_sync;
	logic [2:0]    slp_sync;
	logic          rd_pulse;
	logic          wr_pulse;
	logic          rst_act;
	logic          slp_rise;
	logic          slp_fall;
	logic          crystal_ok;
	logic [7:0]    enable;
	logic [7:0]    flags;
	logic [7:0]    next_flags;
	logic [7:0]    ev_vec;
	logic [7:0]    set_vec;
	logic [7:0]    cross_clr;
	logic          flag_clr;
	logic [7:0]    command_reg;
	logic [3:0]    control_register_zero;
	logic [7:0]    rd_word;
	rsc_state_type state;
	rsc_state_type trans_target;
	logic [2:0]    trans_cnt;
	logic [6:0]    stop_cnt;
	logic          off_pend;
	logic          wr_cmd;
	logic          cmd_force;
	logic          cmd_off;
	logic          busy;
	logic          field_on;
	logic          clk_run;

	// ****************************************************
	// serial port, link clock domain
	// ****************************************************
	function automatic logic [7:0] status_of(input rsc_state_type s);
		unique case (s)
			S_P_ON:       status_of = CODE_P_ON;
			S_IDLE:       status_of = CODE_IDLE;
			S_SLEEP_WAIT: status_of = CODE_TRANSITION;
			S_SLEEP:      status_of = CODE_SLEEP;
			S_RX_ON:      status_of = CODE_RX_ON;
			S_RX_NOCLK:   status_of = CODE_RX_NOCLK;
			S_BUSY_RX:    status_of = CODE_BUSY_RX;
			S_PLL_ON:     status_of = CODE_PLL_ON;
			S_BUSY_TX:    status_of = CODE_BUSY_TX;
			S_TRANS:      status_of = CODE_TRANSITION;
		endcase
	endfunction

	// frame control, cleared by the select line between frames
	always_ff @(posedge sclk or posedge sel_n) begin
		if (sel_n) begin
			bit_cnt  <= 5'h00;
			shift_in <= 8'h00;
			frame_ok <= 1'b0;
			rd_req   <= 1'b0;
			wr_req   <= 1'b0;
			miso_oe  <= 1'b0;
			miso     <= 1'b0;
		end else begin
			miso_oe  <= 1'b1;
			shift_in <= {shift_in[6:0], mosi};
			if (bit_cnt != SPI_FRAME_BITS) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
			if (bit_cnt == SPI_ADDR_LAST) begin
				frame_ok <= shift_in[6];
				rd_req   <= shift_in[6] & ~shift_in[5];
			end
			if (bit_cnt == SPI_FRAME_LAST) begin
				// the shift register holds data bits 7 to 1 here, so the wr_bit stored with the address gates
				wr_req <= frame_ok & wr_bit;
			end
			// rd_word is stable here: host pauses after the address byte
			if (bit_cnt >= SPI_DATA_FIRST && bit_cnt <= SPI_FRAME_LAST) begin
				miso <= rd_word[3'(SPI_FRAME_LAST - bit_cnt)];
			end else begin
				miso <= 1'b0;
			end
		end
	end

	// address and data are held past the frame for the crossing
	always_ff @(posedge sclk) begin
		if (!sel_n && bit_cnt == SPI_ADDR_LAST) begin
			spi_addr <= {shift_in[4:0], mosi};
			wr_bit   <= shift_in[5];
		end
		if (!sel_n && bit_cnt == SPI_FRAME_LAST) begin
			spi_data <= {shift_in[6:0], mosi};
		end
	end

	// ****************************************************
	// crossings and pin synchronisers
	// ****************************************************
	// requests are levels held until select rises, so edge detect is safe
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_sync   <= 3'h0;
			wr_sync   <= 3'h0;
			rst_sync  <= 2'h3;
			xtal_sync <= 2'h0;
			slp_sync  <= 3'h0;
		end else begin
			rd_sync   <= {rd_sync[1:0], rd_req};
			wr_sync   <= {wr_sync[1:0], wr_req};
			rst_sync  <= {rst_sync[0], reset_pin_n};
			xtal_sync <= {xtal_sync[0], crystal_stable};
			slp_sync  <= {slp_sync[1:0], sleep_transmit_pin};
		end
	end

	assign rd_pulse   = rd_sync[1] & ~rd_sync[2];
	assign wr_pulse   = wr_sync[1] & ~wr_sync[2];
	assign rst_act    = ~rst_sync[1];
	assign crystal_ok = xtal_sync[1];
	assign slp_rise   = slp_sync[1] & ~slp_sync[2];
	assign slp_fall   = ~slp_sync[1] & slp_sync[2];

	// ****************************************************
	// registers
	// ****************************************************
	assign wr_cmd    = wr_pulse && spi_addr == ADDR_COMMAND;
	assign cmd_force = wr_cmd && spi_data == CMD_FORCE_OFF;
	assign cmd_off   = wr_cmd && spi_data == CMD_OFF;

	// reset pin spares the clock output control, only srst loads it
	always_ff @(posedge clk) begin
		if (srst) begin
			control_register_zero <= CTRL0_RESET;
		end else if (wr_pulse && spi_addr == ADDR_CTRL0) begin
			control_register_zero <= spi_data[3:0];
		end
	end

	// enables, reserved bits stored but never used
	always_ff @(posedge clk) begin
		if (srst || rst_act) begin
			enable      <= ENABLE_RESET;
			command_reg <= COMMAND_RESET;
		end else begin
			if (wr_pulse && spi_addr == ADDR_ENABLE) begin
				enable <= spi_data;
			end
			if (wr_cmd) begin
				command_reg <= spi_data;
			end
		end
	end

	// read data captured once per read; flags cleared in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_word <= 8'h00;
		end else if (rd_pulse) begin
			unique case (spi_addr)
				ADDR_STATUS:  rd_word <= status_of(state);
				ADDR_COMMAND: rd_word <= command_reg;
				ADDR_CTRL0:   rd_word <= {4'h0, control_register_zero};
				ADDR_ENABLE:  rd_word <= enable;
				ADDR_FLAGS:   rd_word <= flags;
				default:      rd_word <= 8'h00;
			endcase
		end
	end

	// ****************************************************
	// interrupt flags
	// ****************************************************
	assign ev_vec = {ev_low_battery, ev_buffer_underrun, 2'b00, ev_frame_end,
		ev_rx_start, ev_pll_unlock, ev_pll_lock};
	assign set_vec  = ev_vec & enable & ~RESERVED_MASK;
	assign flag_clr = rd_pulse && spi_addr == ADDR_FLAGS;

	// lock and unlock knock each other out, set beats a read clear
	always_comb begin
		cross_clr                 = 8'h00;
		cross_clr[BIT_PLL_UNLOCK] = set_vec[BIT_PLL_LOCK];
		cross_clr[BIT_PLL_LOCK]   = set_vec[BIT_PLL_UNLOCK];
	end

	for (genvar i = 0; i < 8; i++) begin : g_flag
		assign next_flags[i] = RESERVED_MASK[i] ? 1'b0 :
			(set_vec[i] | (flags[i] & ~flag_clr & ~cross_clr[i]));
	end

	always_ff @(posedge clk) begin
		if (srst || rst_act) begin
			flags <= FLAGS_RESET;
			irq   <= 1'b0;
		end else begin
			flags <= next_flags;
			irq   <= |next_flags;
		end
	end

	// ****************************************************
	// state control
	// ****************************************************
	assign busy     = state == S_BUSY_RX || state == S_BUSY_TX;
	assign field_on = control_register_zero[CLKOUT_CTRL_MSB:0] != 3'h0;

	always_ff @(posedge clk) begin
		if (srst) begin
			state        <= S_P_ON;
			trans_target <= S_IDLE;
			trans_cnt    <= 3'h0;
			stop_cnt     <= 7'h00;
			off_pend     <= 1'b0;
			frame_abort  <= 1'b0;
		end else begin
			frame_abort <= 1'b0;
			if (stop_cnt != 7'h00) begin
				stop_cnt <= stop_cnt - 7'h01;
			end
			if (rst_act) begin
				off_pend <= 1'b0;
				stop_cnt <= 7'h00;
				if (state != S_P_ON) begin
					state <= S_IDLE;
				end
			end else if ((cmd_force || cmd_off) && state == S_P_ON) begin
				if (crystal_ok) begin
					state        <= S_TRANS;
					trans_target <= S_IDLE;
					trans_cnt    <= TRANSITION_CYC;
				end
			end else if (cmd_force) begin
				state       <= S_IDLE;
				off_pend    <= 1'b0;
				stop_cnt    <= 7'h00;
				frame_abort <= busy;
			end else if (cmd_off) begin
				if (busy) begin
					off_pend <= 1'b1;
				end else begin
					state    <= S_IDLE;
					stop_cnt <= 7'h00;
				end
			end else begin
				unique case (state)
					S_P_ON: begin
					end
					S_TRANS: begin
						trans_cnt <= trans_cnt - 3'h1;
						if (trans_cnt == 3'h1) begin
							state <= trans_target;
						end
					end
					S_IDLE: begin
						if (slp_rise) begin
							if (field_on) begin
								state    <= S_SLEEP_WAIT;
								stop_cnt <= SLEEP_DELAY_CYC;
							end else begin
								state <= S_SLEEP;
							end
						end else if (wr_cmd && spi_data == CMD_PLL_ON) begin
							state        <= S_TRANS;
							trans_target <= S_PLL_ON;
							trans_cnt    <= TRANSITION_CYC;
						end else if (wr_cmd && spi_data == CMD_RX_ON) begin
							state        <= S_TRANS;
							trans_target <= S_RX_ON;
							trans_cnt    <= TRANSITION_CYC;
						end
					end
					S_SLEEP_WAIT: begin
						if (slp_fall) begin
							state    <= S_IDLE;
							stop_cnt <= 7'h00;
						end else if (stop_cnt == 7'h01) begin
							state <= S_SLEEP;
						end
					end
					S_SLEEP: begin
						if (slp_fall) begin
							state <= S_IDLE;
						end
					end
					S_RX_ON: begin
						if (slp_rise) begin
							state    <= S_RX_NOCLK;
							stop_cnt <= SLEEP_DELAY_CYC;
						end else if (ev_rx_start) begin
							state <= S_BUSY_RX;
						end else if (wr_cmd && spi_data == CMD_PLL_ON) begin
							state <= S_PLL_ON;
						end
					end
					S_RX_NOCLK: begin
						if (ev_rx_start) begin
							state    <= S_BUSY_RX;
							stop_cnt <= 7'h00;
						end else if (slp_fall) begin
							state    <= S_RX_ON;
							stop_cnt <= 7'h00;
						end
					end
					S_BUSY_RX: begin
						if (ev_frame_end) begin
							state    <= off_pend ? S_IDLE : S_RX_ON;
							off_pend <= 1'b0;
						end
					end
					S_PLL_ON: begin
						if (slp_rise || (wr_cmd && spi_data == CMD_TX_START)) begin
							state <= S_BUSY_TX;
						end else if (wr_cmd && spi_data == CMD_RX_ON) begin
							state <= S_RX_ON;
						end
					end
					S_BUSY_TX: begin
						if (ev_frame_end) begin
							state    <= off_pend ? S_IDLE : S_PLL_ON;
							off_pend <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// ****************************************************
	// clock output, pull resistors, status
	// ****************************************************
	// divide by two; runs down the sleep countdown before stopping
	always_comb begin
		unique case (state)
			S_P_ON:                  clk_run = crystal_ok;
			S_SLEEP_WAIT, S_RX_NOCLK: clk_run = stop_cnt != 7'h00;
			S_SLEEP:                 clk_run = 1'b0;
			default:                 clk_run = 1'b1;
		endcase
		clk_run = clk_run & field_on;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			clock_output_pin <= 1'b0;
			pullup_enable    <= 1'b1;
			state_code       <= CODE_P_ON;
		end else begin
			clock_output_pin <= clk_run ? ~clock_output_pin : 1'b0;
			pullup_enable    <= state == S_P_ON;
			state_code       <= status_of(state);
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_ENABLE_RESET: assert property ($fell(srst) |-> enable == ENABLE_RESET)
		else $error("enable register not all ones after reset");
	AST_RESERVED_FLAGS: assert property ((flags & RESERVED_MASK) == 8'h00)
		else $error("reserved flag bit set");
	AST_FLAG_READ_CLEAR: assert property (flag_clr && set_vec == 8'h00 && !rst_act
		|=> flags == 8'h00 && !irq)
		else $error("flag read did not clear flags and interrupt");
	AST_IRQ_OR: assert property (irq == (|flags))
		else $error("interrupt output differs from OR of flags");
	AST_STICKY: assert property (flags[BIT_LOW_BATTERY] && !flag_clr && !rst_act
		|=> flags[BIT_LOW_BATTERY])
		else $error("flag dropped without a read");
	AST_LOCK_CLEARS: assert property (set_vec[BIT_PLL_LOCK] && !set_vec[BIT_PLL_UNLOCK]
		&& !rst_act |=> flags[BIT_PLL_LOCK] && !flags[BIT_PLL_UNLOCK])
		else $error("lock did not displace unlock");
	AST_MASKED: assert property (ev_frame_end && !enable[BIT_FRAME_END]
		&& !flags[BIT_FRAME_END] |=> !flags[BIT_FRAME_END])
		else $error("disabled event set its flag");
	AST_SLEEP_AT_ONCE: assert property (state == S_IDLE && slp_rise && !field_on
		&& !rst_act && !wr_cmd |=> state == S_SLEEP)
		else $error("sleep not immediate with clock off");
	AST_SLEEP_DELAY: assert property (state == S_IDLE && slp_rise && field_on
		&& !rst_act && !wr_cmd |=> stop_cnt == SLEEP_DELAY_CYC && state == S_SLEEP_WAIT)
		else $error("sleep countdown not started");
	AST_SLEEP_ENTRY: assert property (state == S_SLEEP_WAIT && stop_cnt == 7'h01
		&& !slp_fall && !rst_act && !wr_cmd |=> state == S_SLEEP ##1 !clock_output_pin)
		else $error("sleep entry or clock stop wrong");
	AST_FORCE_ABORT: assert property (busy && cmd_force && !rst_act
		|=> state == S_IDLE && frame_abort)
		else $error("forced off did not abort frame");
	AST_OFF_DEFER: assert property (state == S_BUSY_RX && cmd_off && !rst_act
		&& !ev_frame_end |=> state == S_BUSY_RX && off_pend)
		else $error("off command not held during frame");
	AST_RESET_P_ON: assert property (state == S_P_ON && rst_act |=> state == S_P_ON)
		else $error("reset pin moved power-on state");
	AST_RESET_IDLE: assert property (state != S_P_ON && rst_act
		|=> state == S_IDLE && enable == ENABLE_RESET)
		else $error("reset pin did not force idle and defaults");
	AST_WAKE: assert property (state == S_SLEEP && slp_fall && !rst_act && !wr_cmd
		|=> state == S_IDLE)
		else $error("falling pin did not wake");

	COV_SLEEP: cover property (state == S_SLEEP_WAIT ##1 state == S_SLEEP);
	COV_RX_FRAME: cover property (state == S_RX_NOCLK ##1 state == S_BUSY_RX);
	COV_READ_CLEAR: cover property (flag_clr && flags != 8'h00);
	COV_ABORT: cover property (frame_abort);

endmodule // rsc_radio_ctrl

/* verification/rsc_host_model.sv */
`timescale 1ns/1ps
module rsc_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      sel_n,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	// ****************************************************
	// serial master: clock runs only inside frames
	// ****************************************************
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		mosi = 1'b1;
	end

	// one frame: header byte, pause so read data can cross, data byte
	task automatic xfer(input logic [7:0] hdr, input logic [7:0] wdat, output logic [7:0] rdat);
		logic [15:0] sh;
		int          i;
		sh = {hdr, wdat};
		rdat = 8'h00;
		@(posedge clk);
		sel_n <= 1'b0;
		#13;
		for (i = 0; i < 16; i++) begin
			if (i == 8)
				repeat (8) @(posedge clk);
			mosi = sh[15 - i];
			#32 sclk = 1'b1;
			#32 sclk = 1'b0;
			if (i > 7)
				rdat[15 - i] = miso & miso_oe;
		end
		mosi = ~mosi; // no stale bit left after the frame
		repeat (5) @(posedge clk);
		sel_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
endmodule // rsc_host_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
	import rsc_pkg::*;
	logic       clk, srst, reset_pin_n, sleep_transmit_pin, crystal_stable;
	logic       sclk, sel_n, mosi, miso, miso_oe, irq, clock_output_pin;
	logic       pullup_enable, frame_abort, a, b;
	logic [7:0] ev, state_code, rd;
	int         num_errors, check_count, n, i;

	// ****************************************************
	// clock, design and host
	// ****************************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	rsc_radio_ctrl u_rsc_radio_ctrl (.clk(clk), .srst(srst), .sclk(sclk), .sel_n(sel_n),
		.mosi(mosi), .miso(miso), .miso_oe(miso_oe), .reset_pin_n(reset_pin_n),
		.sleep_transmit_pin(sleep_transmit_pin), .crystal_stable(crystal_stable),
		.ev_low_battery(ev[7]), .ev_buffer_underrun(ev[6]), .ev_frame_end(ev[3]),
		.ev_rx_start(ev[2]), .ev_pll_unlock(ev[1]), .ev_pll_lock(ev[0]), .irq(irq),
		.clock_output_pin(clock_output_pin), .pullup_enable(pullup_enable),
		.frame_abort(frame_abort), .state_code(state_code));
	rsc_host_model u_rsc_host_model (.clk(clk), .sclk(sclk), .sel_n(sel_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe));

	// ****************************************************
	// shared tasks
	// ****************************************************
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check1(input string what, input logic exp, input logic got);
		check8(what, {7'h00, exp}, {7'h00, got});
	endtask

	task automatic wr(input logic [5:0] ad, input logic [7:0] d);
		u_rsc_host_model.xfer({2'b11, ad}, d, rd);
	endtask

	task automatic rdchk(input string what, input logic [5:0] ad, input logic [7:0] exp);
		u_rsc_host_model.xfer({2'b10, ad}, 8'h00, rd);
		check8(what, exp, rd);
	endtask

	// bounded wait, a timeout is a mismatch
	task automatic wait_code(input logic [7:0] code);
		int k;
		for (k = 0; k < 300 && state_code !== code; k++)
			@(negedge clk);
		check8("state", code, state_code);
		if (k == 300)
			final_report();
	endtask

	task automatic count_trans();
		int k;
		n = 0;
		for (k = 0; k < 300 && state_code !== CODE_SLEEP; k++) begin
			@(negedge clk);
			if (state_code === CODE_TRANSITION)
				n++;
		end
		if (k == 300) begin
			num_errors++;
			final_report();
		end
	endtask

	task automatic pulse(input logic [7:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 8'h00;
		repeat (3) @(negedge clk);
	endtask

	task automatic set_pin(input logic v);
		@(posedge clk);
		sleep_transmit_pin <= v;
	endtask

	task automatic pin_reset();
		@(posedge clk);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (6) @(negedge clk);
	endtask

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic t_reset();
		check8("state", CODE_P_ON, state_code);
		check1("pullup", 1'b1, pullup_enable);
		check1("clock out idle", 1'b0, clock_output_pin);
		rdchk("enable", ADDR_ENABLE, 8'hFF);
		rdchk("flags", ADDR_FLAGS, 8'h00);
		pin_reset();
		rdchk("status", ADDR_STATUS, CODE_P_ON);
	endtask

	// off before the crystal settles must be refused
	task automatic t_power_on();
		wr(ADDR_COMMAND, CMD_OFF);
		rdchk("status", ADDR_STATUS, CODE_P_ON);
		crystal_stable <= 1'b1;
		wr(ADDR_COMMAND, CMD_OFF);
		wait_code(CODE_IDLE);
		check1("pullup", 1'b0, pullup_enable);
		rdchk("status", ADDR_STATUS, CODE_IDLE);
	endtask

	task automatic t_irq();
		for (i = 0; i < 8; i++) begin
			if (i != 4 && i != 5) begin
				pulse(8'h01 << i);
				check1("irq", 1'b1, irq);
				rdchk("flags", ADDR_FLAGS, 8'h01 << i);
				check1("irq", 1'b0, irq);
				rdchk("flags", ADDR_FLAGS, 8'h00);
			end
		end
		wr(ADDR_ENABLE, 8'h30);
		rdchk("enable", ADDR_ENABLE, 8'h30);
		pulse(8'hCF);
		check1("irq", 1'b0, irq);
		rdchk("flags", ADDR_FLAGS, 8'h00);
		wr(ADDR_ENABLE, 8'hFF);
		pulse(8'h01);
		pulse(8'h80);
		pulse(8'h02);
		rdchk("flags", ADDR_FLAGS, 8'h82);
	endtask

	task automatic t_sleep();
		@(negedge clk) a = clock_output_pin;
		@(negedge clk) b = clock_output_pin;
		check1("clock out running", ~a, b);
		set_pin(1'b1);
		fork
			count_trans();
			rdchk("status", ADDR_STATUS, CODE_TRANSITION);
		join
		wait_code(CODE_SLEEP);
		check8("sleep delay", {1'b0, SLEEP_DELAY_CYC}, 8'(n));
		@(negedge clk) a = clock_output_pin;
		@(negedge clk) b = clock_output_pin;
		check8("clock out stopped", 8'h00, {6'h00, a, b});
		set_pin(1'b0);
		wait_code(CODE_IDLE);
		wr(ADDR_CTRL0, 8'h00);
		set_pin(1'b1);
		count_trans();
		wait_code(CODE_SLEEP);
		check8("sleep delay", 8'h00, 8'(n));
		set_pin(1'b0);
		wait_code(CODE_IDLE);
		wr(ADDR_CTRL0, 8'h01);
	endtask

	task automatic t_busy();
		wr(ADDR_COMMAND, CMD_RX_ON);
		wait_code(CODE_RX_ON);
		set_pin(1'b1);
		wait_code(CODE_RX_NOCLK);
		pulse(8'h04);
		wait_code(CODE_BUSY_RX);
		set_pin(1'b0);
		wr(ADDR_COMMAND, CMD_OFF);
		check8("state", CODE_BUSY_RX, state_code);
		pulse(8'h08);
		wait_code(CODE_IDLE);
		wr(ADDR_COMMAND, CMD_PLL_ON);
		wait_code(CODE_PLL_ON);
		set_pin(1'b1);
		wait_code(CODE_BUSY_TX);
		set_pin(1'b0);
		a = 1'b0;
		fork
			wr(ADDR_COMMAND, CMD_FORCE_OFF);
			for (int k = 0; k < 60; k++)
				@(negedge clk) a = a | (frame_abort === 1'b1);
		join
		check1("abort", 1'b1, a);
		wait_code(CODE_IDLE);
		wr(ADDR_COMMAND, CMD_PLL_ON);
		wait_code(CODE_PLL_ON);
		wr(ADDR_COMMAND, CMD_TX_START);
		wait_code(CODE_BUSY_TX);
		pulse(8'h08);
		wait_code(CODE_PLL_ON);
		wr(ADDR_COMMAND, CMD_RX_ON);
		wait_code(CODE_RX_ON);
		wr(ADDR_COMMAND, CMD_OFF);
		wait_code(CODE_IDLE);
	endtask

	// frame events above left receive start and frame end pending
	task automatic t_pin_reset();
		check1("irq", 1'b1, irq);
		rdchk("flags", ADDR_FLAGS, 8'h0C);
		wr(ADDR_ENABLE, 8'h00);
		wr(ADDR_CTRL0, 8'h02);
		wr(ADDR_COMMAND, CMD_RX_ON);
		wait_code(CODE_RX_ON);
		pin_reset();
		wait_code(CODE_IDLE);
		rdchk("enable", ADDR_ENABLE, 8'hFF);
		rdchk("control", ADDR_CTRL0, 8'h02);
	endtask

	// ****************************************************
	// main sequence: inputs idle from time zero, crystal unstable until the power-on scenario
	// ****************************************************
	initial begin
		srst = 1'b1;
		reset_pin_n = 1'b1;
		sleep_transmit_pin = 1'b0;
		crystal_stable = 1'b0;
		ev = 8'h00;
		num_errors = 0;
		check_count = 0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_power_on();
		t_irq();
		t_sleep();
		t_busy();
		t_pin_reset();
		final_report();
	end
endmodule // tb
